// ### serial_cfg_clocking.sv
// Mode select, format and transfer clock front end of one serial channel
`timescale 1ns/1ns

// Overview of operation
// R1 - Peripheral clock must run before any configuration or start.
// R2 - UART and I2C master divide timer output by eight.
// R3 - SPI normal divides timer output by two; fast mode uses core clock.
// R4 - I2C slave bit clock is external; undivided timer tick for sampling.
// R5 - Software sets timer rate to eight times the external clock.
// R6 - Slave holds clock low on done flag, unless status means stop.
// R7 - Trigger releases clock two timer ticks after operation start.
// R8 - Data or acknowledge transmit drives output one cycle after trigger.
// R9 - Interface codes: 0 reset, 1 UART, 2 SPI, 4/5 I2C; rest reserved.
// R10 - Reset code clears all internal circuits of the channel.
// R11 - Software resets, then selects mode, before other configuration.
// R12 - Bit order 0 is LSB first (default), 1 is MSB first.
// R13 - Character length 0 gives seven bits, 1 gives eight.
// R14 - Every UART frame has exactly one start bit.
// R15 - Stop bit select 0 gives one, 1 gives two stop bits.
// R16 - Parity enable adds and checks a parity bit; off by default.
// R17 - Parity type 0 is odd (default), 1 is even.
// R18 - Non-UART setup order: pins, clock, reset, mode, format, interrupts.
// R19 - UART is configured before pins switch, avoiding false start bits.
// R20 - Serial pins sit low after reset.
// R21 - In reset code, shifters and flags stay cleared, outputs inactive.
module serial_cfg_clocking (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Configuration writes
    input wire logic cfgWrite,
    input wire logic [2:0] interfaceSelectIn,
    input wire logic bitOrderSelectIn,
    input wire logic charLengthSelectIn,
    input wire logic stopBitsSelectIn,
    input wire logic parityEnableIn,
    input wire logic parityTypeSelectIn,
    input wire logic spiFastModeIn,
    // Timer source tick, one core cycle per timer output period
    input wire logic timerTick,
    // I2C slave operation control
    input wire logic slaveOpTrigger,
    input wire logic [2:0] slaveOpSelect,
    input wire logic slaveOpDoneSet,
    input wire logic [2:0] slaveStatusCode,
    input wire logic slaveTxBit,
    input wire logic slaveOpDoneClear,
    // Configuration state
    output logic [2:0] interfaceSelect,
    output logic channelReset,
    output logic modeReserved,
    output logic bitOrderSelect,
    output logic charLengthSelect,
    output logic stopBitsSelect,
    output logic parityEnable,
    output logic parityTypeSelect,
    output logic [3:0] frameBits,
    // Generated clocks
    output logic transferTick,
    output logic samplingTick,
    // I2C slave line drive
    output logic slaveOpDoneFlag,
    output logic sclOut,
    output logic sclOe,
    output logic sdaOut,
    output logic sdaOe
);
    // Slave release sequencer states, Gray from idle to hold
    typedef enum logic [1:0] {
        SL_IDLE = 2'b00,
        SL_WAIT = 2'b01,
        SL_HOLD = 2'b11
    } slave_state_t;

    slave_state_t slState_q, slState_d;
    logic [1:0] relCnt_q, relCnt_d;
    logic stretch_q, stretch_d;
    logic fastMode_q;
    logic div8Tick, div2Tick, tickSel;
    logic isReset, isUart, isSpi, isI2cM, isI2cS, txOp;
    logic [3:0] frameLen;
    logic relDone;

    // Mode decode
    assign isReset = (interfaceSelect == serial_cfg_pkg::MODE_RESET);
    assign isUart = (interfaceSelect == serial_cfg_pkg::MODE_UART);
    assign isSpi = (interfaceSelect == serial_cfg_pkg::MODE_SPI_MASTER);
    assign isI2cM = (interfaceSelect == serial_cfg_pkg::MODE_I2C_MASTER);
    assign isI2cS = (interfaceSelect == serial_cfg_pkg::MODE_I2C_SLAVE);
    assign txOp = (slaveOpSelect == serial_cfg_pkg::SOP_TX_DATA) ||
                  (slaveOpSelect == serial_cfg_pkg::SOP_TX_ACK);
    // Tick that completes the release count after a trigger
    assign relDone = (relCnt_q + 2'h1 == serial_cfg_pkg::SCL_RELEASE_TICKS);

    // Configuration register; reset code clears every other field
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            interfaceSelect <= serial_cfg_pkg::IFSEL_RESET_VAL; // [R9]
            bitOrderSelect <= serial_cfg_pkg::BIT_ORDER_RESET; // [R12]
            charLengthSelect <= serial_cfg_pkg::CHAR_LEN_RESET; // [R13]
            stopBitsSelect <= serial_cfg_pkg::STOP_BITS_RESET; // [R15]
            parityEnable <= serial_cfg_pkg::PARITY_EN_RESET; // [R16]
            parityTypeSelect <= serial_cfg_pkg::PARITY_TYPE_RESET; // [R17]
            fastMode_q <= 1'b0;
        end else if (cfgWrite) begin
            interfaceSelect <= interfaceSelectIn; // [R9]
            if (interfaceSelectIn == serial_cfg_pkg::MODE_RESET) begin
                bitOrderSelect <= serial_cfg_pkg::BIT_ORDER_RESET; // [R10]
                charLengthSelect <= serial_cfg_pkg::CHAR_LEN_RESET;
                stopBitsSelect <= serial_cfg_pkg::STOP_BITS_RESET;
                parityEnable <= serial_cfg_pkg::PARITY_EN_RESET;
                parityTypeSelect <= serial_cfg_pkg::PARITY_TYPE_RESET;
                fastMode_q <= 1'b0;
            end else begin
                bitOrderSelect <= bitOrderSelectIn; // [R12]
                charLengthSelect <= charLengthSelectIn; // [R13]
                stopBitsSelect <= stopBitsSelectIn; // [R15]
                parityEnable <= parityEnableIn; // [R16]
                parityTypeSelect <= parityTypeSelectIn; // [R17]
                fastMode_q <= spiFastModeIn;
            end
        end
    end

    // Frame length: one start, data, optional parity, stop bits
    assign frameLen = serial_cfg_pkg::START_BITS // [R14]
        + (charLengthSelect ? serial_cfg_pkg::DATA_BITS_LONG
                            : serial_cfg_pkg::DATA_BITS_SHORT) // [R13]
        + {3'h0, parityEnable} // [R16]
        + (stopBitsSelect ? serial_cfg_pkg::STOP_BITS_TWO
                          : serial_cfg_pkg::STOP_BITS_ONE); // [R15]

    // Dividers are held cleared in the reset code
    tick_divider #(.RATIO(serial_cfg_pkg::DIV_UART_I2C)) u_div8 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clear(isReset), // [R21]
        .srcTick(timerTick),
        .divTick(div8Tick)
    );

    tick_divider #(.RATIO(serial_cfg_pkg::DIV_SPI)) u_div2 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clear(isReset), // [R21]
        .srcTick(timerTick),
        .divTick(div2Tick)
    );

    // Transfer tick per mode; fast SPI ticks every core clock
    assign tickSel = ((isUart | isI2cM) & div8Tick) // [R2]
                   | (isSpi & (fastMode_q ? 1'b1 : div2Tick)); // [R3]

    // Slave release sequencer next state
    always_comb begin
        slState_d = slState_q;
        relCnt_d = relCnt_q;
        stretch_d = stretch_q;
        case (slState_q)
            SL_IDLE: begin
                if (slaveOpTrigger) begin
                    slState_d = SL_WAIT;
                    relCnt_d = '0;
                end
            end
            SL_WAIT: begin
                if (timerTick) begin
                    relCnt_d = relCnt_q + 2'h1;
                    if (relDone) begin
                        stretch_d = 1'b0; // [R7]
                        slState_d = SL_HOLD;
                    end
                end
            end
            SL_HOLD: begin
                slState_d = SL_IDLE;
            end
            default: begin
                slState_d = SL_IDLE;
            end
        endcase
        // Completion with any status but stop stretches in any state; set beats a same-cycle release
        if (slaveOpDoneSet &&
            slaveStatusCode != serial_cfg_pkg::STATUS_STOP) begin
            stretch_d = 1'b1; // [R6]
        end
    end

    // Slave sequencer and line drive; all idle outside slave mode
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            slState_q <= SL_IDLE;
            relCnt_q <= '0;
            stretch_q <= 1'b0;
        end else if (!isI2cS) begin
            slState_q <= SL_IDLE; // [R21]
            relCnt_q <= '0;
            stretch_q <= 1'b0;
        end else begin
            slState_q <= slState_d;
            relCnt_q <= relCnt_d;
            stretch_q <= stretch_d;
        end
    end

    // Registered outputs; pins low and undriven until a mode is chosen
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            channelReset <= 1'b1;
            modeReserved <= 1'b0;
            frameBits <= '0;
            transferTick <= 1'b0;
            samplingTick <= 1'b0;
            slaveOpDoneFlag <= 1'b0;
            sclOut <= 1'b0; // [R20]
            sclOe <= 1'b0;
            sdaOut <= 1'b0; // [R20]
            sdaOe <= 1'b0;
        end else begin
            channelReset <= isReset; // [R10]
            modeReserved <= ~(isReset | isUart | isSpi | isI2cM | isI2cS);
            frameBits <= isUart ? frameLen : 4'h0;
            transferTick <= tickSel;
            samplingTick <= isI2cS & timerTick; // [R4]
            // Set wins over clear so no completion is lost
            if (!isI2cS) begin
                slaveOpDoneFlag <= 1'b0; // [R21]
            end else if (slaveOpDoneSet) begin
                slaveOpDoneFlag <= 1'b1;
            end else if (slaveOpDoneClear) begin
                slaveOpDoneFlag <= 1'b0;
            end
            // Open drain: only ever pull low
            sclOut <= 1'b0;
            sclOe <= isI2cS & stretch_d; // [R6]
            // Transmit data starts the cycle after the trigger
            sdaOut <= 1'b0;
            if (!isI2cS) begin
                sdaOe <= 1'b0;
            end else if (slaveOpTrigger) begin
                sdaOe <= txOp & ~slaveTxBit; // [R8]
            end
        end
    end
endmodule // serial_cfg_clocking

// ### serial_cfg_pkg.sv
// Constants shared by the serial channel configuration and clocking block
package serial_cfg_pkg;
    // Interface select encodings
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [2:0] MODE_UART = 3'h1;
    localparam logic [2:0] MODE_SPI_MASTER = 3'h2;
    localparam logic [2:0] MODE_I2C_MASTER = 3'h4;
    localparam logic [2:0] MODE_I2C_SLAVE = 3'h5;
    localparam logic [2:0] IFSEL_RESET_VAL = 3'h0;
    // Slave status code for a detected stop
    localparam logic [2:0] STATUS_STOP = 3'h1;
    // Slave operation select codes
    localparam logic [2:0] SOP_TX_DATA = 3'h2;
    localparam logic [2:0] SOP_TX_ACK = 3'h3;
    // Divider ratios of the source clock
    localparam int DIV_UART_I2C = 8;
    localparam int DIV_SPI = 2;
    // Timer ticks from slave operation start to clock release
    localparam logic [1:0] SCL_RELEASE_TICKS = 2'h2;
    // Format field reset values
    localparam logic BIT_ORDER_RESET = 1'b0;
    localparam logic CHAR_LEN_RESET = 1'b0;
    localparam logic STOP_BITS_RESET = 1'b0;
    localparam logic PARITY_EN_RESET = 1'b0;
    localparam logic PARITY_TYPE_RESET = 1'b0;
    // UART frame field lengths
    localparam logic [3:0] START_BITS = 4'h1;
    localparam logic [3:0] DATA_BITS_SHORT = 4'h7;
    localparam logic [3:0] DATA_BITS_LONG = 4'h8;
    localparam logic [3:0] STOP_BITS_ONE = 4'h1;
    localparam logic [3:0] STOP_BITS_TWO = 4'h2;
endpackage

// ### tick_divider.sv
// Divides an enable-rate source tick down by a ratio
`timescale 1ns/1ns
module tick_divider #(
    parameter int RATIO = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Control
    input wire logic clear,
    input wire logic srcTick,
    // Output
    output logic divTick
);
    localparam int CW = $clog2(RATIO);
    logic [CW-1:0] cnt_q;
    logic wrap;

    assign wrap = (cnt_q == CW'(RATIO - 1));

    // Count source ticks, pulse once per full ratio
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            divTick <= 1'b0;
        end else if (clear) begin
            cnt_q <= '0;
            divTick <= 1'b0;
        end else begin
            divTick <= srcTick & wrap;
            if (srcTick) begin
                cnt_q <= wrap ? '0 : cnt_q + 1'b1;
            end
        end
    end
endmodule // tick_divider

// ### timer_tick_model.sv
// Far-side model: fine rate timer output and pulled-up clock line
`timescale 1ns/1ns
module timer_tick_model #(
    parameter int PERIOD = 4
) (
    // Clock and channel drive
    input wire logic core_clk,
    input wire logic sclOe,
    // Timer pulse and resolved line
    output logic timerTick,
    output wire logic sclLine
);
    int cnt = 0;
    initial timerTick = 1'b0;
    // Free-running timer, rate chosen as eight times the bus clock
    always @(negedge core_clk) begin
        cnt = (cnt + 1) % PERIOD;
        timerTick <= (cnt == 0); // Runs from time zero, clock first
    end
    // Pull-up wins whenever the channel lets go of the line
    assign sclLine = sclOe ? 1'b0 : 1'b1;
endmodule // timer_tick_model

// ### serial_cfg_clocking_sva.sv
// Port checker for the serial configuration and clocking block
`timescale 1ns/1ns
module serial_cfg_clocking_sva (
    // Clock, reset and inputs
    input wire logic core_clk, rst_n, cfgWrite, timerTick, slaveTxBit,
    input wire logic [2:0] interfaceSelectIn, slaveOpSelect, slaveStatusCode,
    input wire logic charLengthSelectIn, stopBitsSelectIn, parityEnableIn,
    input wire logic slaveOpTrigger, slaveOpDoneSet,
    // Outputs
    input wire logic [2:0] interfaceSelect,
    input wire logic channelReset, bitOrderSelect, parityEnable,
    input wire logic [3:0] frameBits,
    input wire logic transferTick, samplingTick, slaveOpDoneFlag, sclOe, sdaOe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Slave mode as held, with no write in flight
    wire slv = interfaceSelect == serial_cfg_pkg::MODE_I2C_SLAVE && !cfgWrite;
    a_mode_load: assert property (
        cfgWrite |=> interfaceSelect == $past(interfaceSelectIn))
        else $error("mode code not loaded");
    a_reset_clears: assert property (
        cfgWrite && interfaceSelectIn == serial_cfg_pkg::MODE_RESET |=>
        !bitOrderSelect && !parityEnable ##1 channelReset)
        else $error("reset code left state behind");
    a_frame_length: assert property (
        cfgWrite && interfaceSelectIn == serial_cfg_pkg::MODE_UART |-> ##2
        frameBits == 4'h9 + {3'h0, $past(charLengthSelectIn, 2)} +
        {3'h0, $past(parityEnableIn, 2)} + {3'h0, $past(stopBitsSelectIn, 2)})
        else $error("frame length wrong");
    a_sample_tick: assert property (
        samplingTick |-> $past(timerTick) && $past(interfaceSelect) == 3'h5)
        else $error("sampling tick without cause");
    a_uart_divide: assert property (
        transferTick && interfaceSelect == 3'h1 |-> $past(timerTick, 2))
        else $error("uart tick off timer");
    a_slave_stretch: assert property (
        slv && slaveOpDoneSet && !slaveOpTrigger && slaveStatusCode != 3'h1
        |=> sclOe && slaveOpDoneFlag) else $error("no stretch on done");
    a_stop_release: assert property (
        slv && slaveOpDoneSet && !slaveOpTrigger && slaveStatusCode == 3'h1
        && !sclOe |=> !sclOe && slaveOpDoneFlag)
        else $error("stretch on stop");
    a_tx_drive: assert property (
        slv && slaveOpTrigger && !slaveTxBit &&
        slaveOpSelect inside {3'h2, 3'h3} |=> sdaOe)
        else $error("data not driven");
endmodule // serial_cfg_clocking_sva
bind serial_cfg_clocking serial_cfg_clocking_sva u_sva (.*);

// ### testbench.sv
// Self-checking bench for the serial configuration and clocking block
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
    $display("MISMATCH %0t line %0d", $time, `__LINE__); end end
module testbench;
    logic core_clk, rst_n, cfgWrite, timerTick, slaveOpTrigger, sclLine;
    logic bitOrderSelectIn, charLengthSelectIn, stopBitsSelectIn;
    logic parityEnableIn, parityTypeSelectIn, spiFastModeIn, slaveTxBit;
    logic slaveOpDoneSet, slaveOpDoneClear, channelReset, modeReserved;
    logic [2:0] interfaceSelectIn, slaveOpSelect, slaveStatusCode;
    logic [2:0] interfaceSelect;
    logic bitOrderSelect, charLengthSelect, stopBitsSelect, parityEnable;
    logic parityTypeSelect, transferTick, samplingTick, slaveOpDoneFlag;
    logic sclOut, sclOe, sdaOut, sdaOe;
    logic [3:0] frameBits;
    int error_cnt = 0;
    int checks_done = 0;
    serial_cfg_clocking u_dut (.*);
    timer_tick_model #(.PERIOD(4)) u_timer (.core_clk(core_clk),
        .sclOe(sclOe), .timerTick(timerTick), .sclLine(sclLine));
    // Free-running core clock, 8 ns period
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic test_done;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // One write pulse, then settle past the two-cycle outputs
    task automatic cfg(input logic [2:0] m, input logic [5:0] f);
        @(negedge core_clk);
        {bitOrderSelectIn, charLengthSelectIn, stopBitsSelectIn,
            parityEnableIn, parityTypeSelectIn, spiFastModeIn} = f;
        interfaceSelectIn = m;
        cfgWrite = 1'b1;
        @(negedge core_clk);
        cfgWrite = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask
    // Cycles between two ticks; a missing tick ends the run
    task automatic gap(input bit samp, input int exp);
        int n;
        n = 0;
        while ((samp ? samplingTick : transferTick) !== 1'b1 && n < 99) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(n < 99, 1'b1)
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while ((samp ? samplingTick : transferTick) !== 1'b1 && n < 99);
        `CHK(n, exp)
        if (n >= 99) test_done();
    endtask
    task automatic t_format;
        cfg(3'h0, 6'h00);
        cfg(3'h1, 6'h3E);
        `CHK({bitOrderSelect, charLengthSelect, stopBitsSelect}, 3'h7)
        `CHK({parityEnable, parityTypeSelect, frameBits}, 6'h3C)
        cfg(3'h1, 6'h10);
        `CHK({bitOrderSelect, parityTypeSelect, frameBits}, 6'h0A)
        cfg(3'h0, 6'h3F);
        `CHK({channelReset, bitOrderSelect, charLengthSelect}, 3'h4)
    endtask
    task automatic t_modes;
        for (int c = 0; c < 8; c++) begin
            cfg(3'(c), 6'h00);
            `CHK(interfaceSelect, 3'(c))
            `CHK(modeReserved, 1'(c inside {3, 6, 7}))
            if (c == 1) `CHK(frameBits, 4'h9)
        end
    endtask
    task automatic t_clocks;
        logic [2:0] md[4] = '{3'h1, 3'h4, 3'h2, 3'h2};
        int ex[4] = '{32, 32, 8, 1};
        for (int i = 0; i < 4; i++) begin
            cfg(3'h0, 6'h00);
            cfg(md[i], {5'h00, i == 3}); // Last entry runs SPI fast
            gap(1'b0, ex[i]);
        end
        cfg(3'h0, 6'h00);
        cfg(3'h5, 6'h00);
        gap(1'b1, 4);
    endtask
    task automatic done(input logic [2:0] st);
        @(negedge core_clk);
        {slaveStatusCode, slaveOpDoneSet, slaveOpDoneClear} = {st, 2'b10};
        @(negedge core_clk);
        {slaveOpDoneSet, slaveOpDoneClear} = 2'b01;
        @(negedge core_clk);
        slaveOpDoneClear = 1'b0;
    endtask
    task automatic t_slave;
        int k;
        done(3'h1);
        `CHK({sclOe, sclLine}, 2'b01)
        done(3'h2);
        `CHK({sclOe, sclLine}, 2'b10)
        // Trigger just after a tick so no tick shares its edge
        k = 0;
        while (timerTick !== 1'b1 && k < 20) @(posedge core_clk) k++;
        `CHK(k < 20, 1'b1)
        @(negedge core_clk);
        {slaveOpTrigger, slaveOpSelect, slaveTxBit} = {1'b1, 3'h2, 1'b0};
        @(negedge core_clk);
        slaveOpTrigger = 1'b0;
        `CHK({sdaOe, sclOe}, 2'b11)
        k = 0;
        for (int i = 0; i < 40 && k < 2; i++) begin
            @(posedge core_clk);
            if (timerTick === 1'b1) k++;
            @(negedge core_clk);
            `CHK(sclOe, 1'(k < 2))
        end
        repeat (2) @(negedge core_clk);
        `CHK({k, sclOe, sclLine}, {32'd2, 2'b01})
        done(3'h2);
        cfg(3'h0, 6'h00);
        `CHK({sclOe, sdaOe, slaveOpDoneFlag, sclOut, sdaOut}, 5'h0)
    endtask
    initial begin
        {cfgWrite, interfaceSelectIn, bitOrderSelectIn, charLengthSelectIn,
            stopBitsSelectIn, parityEnableIn, parityTypeSelectIn,
            spiFastModeIn, slaveOpTrigger, slaveOpSelect, slaveOpDoneSet,
            slaveStatusCode, slaveTxBit, slaveOpDoneClear, rst_n} = '0;
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        `CHK({interfaceSelect, channelReset, sclOe, sdaOe}, 6'h04)
        `CHK({bitOrderSelect, charLengthSelect}, 2'h0)
        t_format();
        t_modes();
        t_clocks();
        t_slave();
        test_done();
    end
endmodule // testbench
